// >>> shared/ssp_pkg.sv
// Operation
// - Normal mode moves one word per frame
// - Network mode runs 2 to 32 slots
// - Mode select bit alone picks normal/network
// - On-demand is network with one slot
// - Gating bit picks continuous or gated clock
// - Gated mode drives sync, ignores sync input
// - Input flags latched at first bit fall
// - Output flags held constant whole frame
// - Sync select shares clock and frame sync
// - Separate receive and transmit requests
// - Internal clock from prescalers and dividers
// - Gated synchronous pin roles
// - Gated asynchronous pin roles
// - Continuous synchronous pin roles
// - Continuous asynchronous pin roles
// - Length-one clear gives word-length sync
// - Length-one set gives one-bit sync pulse
// - Length-zero set gives opposite directional lengths
// - Early receive sync ignored, reception suppressed
// - Idle gaps allowed, transmit output floats
package ssp_pkg;

  // Widest serial word held by the shift registers
  localparam int unsigned SSP_DATA_W = 24;

  // Word lengths picked by the two word-length bits
  localparam logic [4:0] SSP_WL_8  = 5'h08;
  localparam logic [4:0] SSP_WL_12 = 5'h0c;
  localparam logic [4:0] SSP_WL_16 = 5'h10;
  localparam logic [4:0] SSP_WL_24 = 5'h18;

  // Fixed prescaler: long range multiplies the half period by eight
  localparam int unsigned SSP_PRE_LONG_SHIFT = 3;

  // Reset levels of pins and flags
  localparam logic SSP_RST_LVL = 1'b0;
  localparam logic SSP_OE_OFF  = 1'b1;

  // Frame sequencer states
  typedef enum logic [2:0] {
    SSP_SEQ_IDLE  = 3'h1,
    SSP_SEQ_ARMED = 3'h2,
    SSP_SEQ_WORD  = 3'h4
  } ssp_seq_e;

endpackage

// >>> logic/ssp_frame_seq.sv
`timescale 1ns/1ps
// One direction of framing: sync recognition, bit and slot counting, shifting
module ssp_frame_seq #(
  parameter bit          IS_RX  = 1'b0,
  parameter int unsigned DATA_W = ssp_pkg::SSP_DATA_W
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // Format
  input  wire logic              enable,
  input  wire logic              gated,
  input  wire logic              bitLen,
  input  wire logic [4:0]        wordLen,
  input  wire logic [5:0]        slots,
  // Bit clock events and sync level
  input  wire logic              riseEv,
  input  wire logic              fallEv,
  input  wire logic              syncLvl,
  // Data
  input  wire logic              serIn,
  input  wire logic [DATA_W-1:0] parIn,
  output logic                   serOut,
  output logic                   serOe_n,
  output logic [DATA_W-1:0]      parOut,
  output logic                   wordStrobe,
  output logic                   frameStart,
  output logic                   firstBit
);

  ssp_pkg::ssp_seq_e state_r;   // Framing state
  logic [4:0]        bitCnt_r;  // Next bit to sample
  logic [5:0]        slotCnt_r; // Current time slot
  logic              syncPrev_r; // Sync level at last fall
  logic              suppress_r; // Receive blocked after early sync
  logic [DATA_W-1:0] shReg_r;   // Shift or hold register
  logic              syncEdge, lastBit, lastSlot, inWord;
  logic              armNow, startNow, armLast, bitGo, early, loadNow;
  logic [4:0]        txIdx;
  logic [DATA_W-1:0] wordMask;

  ////////////////////////////////////////////////////////////////////////////
  // Sync recognition
  assign syncEdge = syncLvl & ~syncPrev_r;
  assign inWord   = (state_r == ssp_pkg::SSP_SEQ_WORD);
  assign lastBit  = inWord & (bitCnt_r == wordLen - 5'h01);
  assign lastSlot = (slotCnt_r == slots - 6'h01);
  assign startNow = fallEv & (state_r == ssp_pkg::SSP_SEQ_IDLE) &
                    (gated | (syncEdge & ~bitLen));
  assign armNow   = fallEv & (state_r == ssp_pkg::SSP_SEQ_IDLE) & ~gated & syncEdge & bitLen;
  // Bit sync during the final bit is the legal back-to-back case
  assign armLast  = fallEv & lastBit & lastSlot & ~gated & syncEdge & bitLen;
  assign early    = fallEv & ~gated & syncEdge & ~armLast &
                    ((state_r == ssp_pkg::SSP_SEQ_ARMED) | inWord);
  assign bitGo      = startNow | (fallEv & (state_r == ssp_pkg::SSP_SEQ_ARMED));
  assign firstBit   = bitGo;
  assign frameStart = armNow | startNow | armLast;
  assign loadNow    = frameStart | (fallEv & lastBit & ~lastSlot);
  assign txIdx      = wordLen - 5'h01 - bitCnt_r;
  assign wordMask   = ~({DATA_W{1'b1}} << wordLen);

  // Previous sync level, sampled on the same edge as data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncPrev_r <= ssp_pkg::SSP_RST_LVL;
    end else if (fallEv) begin
      syncPrev_r <= syncLvl & ~gated;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame state, bit and slot counters
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= ssp_pkg::SSP_SEQ_IDLE;
      bitCnt_r  <= 5'h00;
      slotCnt_r <= 6'h00;
    end else if (fallEv) begin
      case (state_r)
        ssp_pkg::SSP_SEQ_IDLE: begin
          if (armNow) begin
            state_r <= ssp_pkg::SSP_SEQ_ARMED;
          end else if (startNow) begin
            state_r  <= ssp_pkg::SSP_SEQ_WORD;
            bitCnt_r <= 5'h01;
          end
        end
        ssp_pkg::SSP_SEQ_ARMED: begin
          state_r  <= ssp_pkg::SSP_SEQ_WORD;
          bitCnt_r <= 5'h01;
        end
        ssp_pkg::SSP_SEQ_WORD: begin
          if (lastBit) begin
            bitCnt_r <= 5'h00;
            if (lastSlot) begin
              slotCnt_r <= 6'h00;
              state_r   <= armLast ? ssp_pkg::SSP_SEQ_ARMED : ssp_pkg::SSP_SEQ_IDLE;
            end else begin
              slotCnt_r <= slotCnt_r + 6'h01;
            end
          end else begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        default: begin
          state_r <= ssp_pkg::SSP_SEQ_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive suppression after a sync that came too early
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      suppress_r <= 1'b0;
    end else if (IS_RX && early) begin
      suppress_r <= 1'b1;
    end else if (frameStart) begin
      suppress_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift, hold and word strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shReg_r    <= '0;
      parOut     <= '0;
      wordStrobe <= 1'b0;
    end else begin
      wordStrobe <= 1'b0;
      if (IS_RX) begin
        // Receive samples on the falling edge, MSB first
        if (fallEv && (bitGo || inWord)) begin
          shReg_r <= {shReg_r[DATA_W-2:0], serIn};
        end
        if (fallEv && lastBit) begin
          parOut     <= {shReg_r[DATA_W-2:0], serIn} & wordMask;
          wordStrobe <= enable & ~suppress_r & ~early;
        end
      end else if (loadNow) begin
        shReg_r    <= parIn;
        wordStrobe <= enable;
      end
    end
  end

  // Transmit bit, first bit set at frame start and later bits on the rising edge; enable every cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      serOut  <= ssp_pkg::SSP_RST_LVL;
      serOe_n <= ssp_pkg::SSP_OE_OFF;
    end else begin
      serOe_n <= IS_RX | ~enable | (state_r == ssp_pkg::SSP_SEQ_IDLE);
      if (frameStart) begin
        serOut <= parIn[wordLen - 5'h01];
      end else if (riseEv && inWord) begin
        serOut <= shReg_r[txIdx];
      end
    end
  end

endmodule

// >>> logic/ssp_serial_mode_top.sv
`timescale 1ns/1ps
// Mode, clock and pin selection around one transmit and one receive framer
module ssp_serial_mode_top #(
  parameter int unsigned DATA_W = ssp_pkg::SSP_DATA_W
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // Second control register bits
  input  wire logic              modeSelect,
  input  wire logic              clockGating,
  input  wire logic              syncSelect,
  input  wire logic              frameLenOne,
  input  wire logic              frameLenZero,
  input  wire logic              clockDirOut,
  input  wire logic [2:0]        pinDirOut,
  input  wire logic [1:0]        outFlag,
  input  wire logic              txEnable,
  input  wire logic              rxEnable,
  // Rate and framing setup
  input  wire logic              prescaleRange,
  input  wire logic [7:0]        prescaleModulus,
  input  wire logic [1:0]        wordLenSel,
  input  wire logic [4:0]        frameDivider,
  // Transmit word side
  input  wire logic [DATA_W-1:0] txWord,
  input  wire logic              txWordValid,
  output logic                   txReq,
  // Receive word side
  output logic [DATA_W-1:0]      rxWord,
  output logic                   rxReq,
  // Captured input flags
  output logic [1:0]             inFlag,
  // Serial clock pin
  input  wire logic              sckIn,
  output logic                   sckOut,
  output logic                   sckOe_n,
  // Multipurpose pins
  input  wire logic [2:0]        mpIn,
  output logic [2:0]             mpOut,
  output logic [2:0]             mpOe_n,
  // Serial data pins
  output logic                   txdOut,
  output logic                   txdOe_n,
  input  wire logic              rxdIn
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [11:0] preCnt_r;     // Half-period prescale counter
  logic        clkLvl_r;     // Internal bit clock level
  logic [9:0]  genBit_r;     // Bit position inside generated frame
  logic        running_r;    // Frame generator active
  logic        lead_r;       // Stand-alone sync bit before a first frame
  logic        sckPrev_r;    // Last sampled serial clock pin
  logic        sc0Prev_r;    // Last sampled first multipurpose pin
  logic [1:0]  flagHeld_r;   // Output flags frozen for the frame
  logic [8:0]  modPlus;
  logic [11:0] preLimit;
  logic        tick, iRise, iFall, dataBit;
  logic [4:0]  wordLen;
  logic [5:0]  frameWords, slots;
  logic [9:0]  period;
  logic        onDemand, demand, frameGo;
  logic        txBitLen, rxBitLen, bitSync, wordSync, syncGenTx, syncGenRx;
  logic        extSckRise, extSckFall, extSc0Rise, extSc0Fall;
  logic        txRise, txFall, rxRise, rxFall, txSync, rxSync;
  logic        txFrameStart, txFirstBit, rxFrameStart, rxFirstBit;
  logic        txdOutW, txdOeW, txStrobe, rxStrobe;
  logic [DATA_W-1:0] rxWordW;

  ////////////////////////////////////////////////////////////////////////////
  // Format decode
  always_comb begin
    case (wordLenSel)
      2'h0:    wordLen = ssp_pkg::SSP_WL_8;
      2'h1:    wordLen = ssp_pkg::SSP_WL_12;
      2'h2:    wordLen = ssp_pkg::SSP_WL_16;
      default: wordLen = ssp_pkg::SSP_WL_24;
    endcase
  end

  assign frameWords = {1'b0, frameDivider} + 6'h01;
  assign slots      = modeSelect ? frameWords : 6'h01;
  assign onDemand   = modeSelect & (frameDivider == 5'h00);
  // On demand, a frame runs only when there is a word to move
  assign demand     = (txEnable & txWordValid) | (rxEnable & ~txEnable);
  assign frameGo    = (txEnable | rxEnable) & (~onDemand | demand);
  assign rxBitLen   = frameLenOne;
  assign txBitLen   = frameLenOne ^ frameLenZero;
  assign period     = 10'({5'h00, wordLen} * {4'h0, frameWords});

  ////////////////////////////////////////////////////////////////////////////
  // Bit rate prescaler
  assign modPlus  = {1'b0, prescaleModulus} + 9'h001;
  assign preLimit = prescaleRange ? ({modPlus, 3'h0} - 12'h001) : ({3'h0, modPlus} - 12'h001);
  assign tick     = (preCnt_r >= preLimit);
  assign iRise    = tick & ~clkLvl_r;
  assign iFall    = tick & clkLvl_r;

  // Half-period counter and internal clock level
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      preCnt_r <= 12'h000;
      clkLvl_r <= ssp_pkg::SSP_RST_LVL;
    end else if (tick) begin
      preCnt_r <= 12'h000;
      clkLvl_r <= ~clkLvl_r;
    end else begin
      preCnt_r <= preCnt_r + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame generator: word-length and frame-rate dividers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      genBit_r  <= 10'h000;
      running_r <= 1'b0;
      lead_r    <= 1'b0;
    end else if (iRise) begin
      if (!running_r) begin
        if (frameGo) begin
          running_r <= 1'b1;
          genBit_r  <= 10'h000;
          lead_r    <= txBitLen | rxBitLen;
        end
      end else if (lead_r) begin
        lead_r <= 1'b0;
      end else if (genBit_r == period - 10'h001) begin
        genBit_r <= 10'h000;
        if (!frameGo) begin
          running_r <= 1'b0;
        end
      end else begin
        genBit_r <= genBit_r + 10'h001;
      end
    end
  end

  assign dataBit  = running_r & ~lead_r;
  assign bitSync  = lead_r | (dataBit & (genBit_r == period - 10'h001) & frameGo);
  assign wordSync = dataBit & (genBit_r < {5'h00, wordLen});
  assign syncGenTx = txBitLen ? bitSync : wordSync;
  assign syncGenRx = rxBitLen ? bitSync : wordSync;

  ////////////////////////////////////////////////////////////////////////////
  // External clock edges; pins are synchronous to sys_clk
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sckPrev_r <= ssp_pkg::SSP_RST_LVL;
      sc0Prev_r <= ssp_pkg::SSP_RST_LVL;
    end else begin
      sckPrev_r <= sckIn;
      sc0Prev_r <= mpIn[0];
    end
  end

  assign extSckRise = sckIn & ~sckPrev_r;
  assign extSckFall = ~sckIn & sckPrev_r;
  assign extSc0Rise = mpIn[0] & ~sc0Prev_r;
  assign extSc0Fall = ~mpIn[0] & sc0Prev_r;

  // Clock and sync routing per direction
  always_comb begin
    // gated clock runs only on data bits
    txRise = clockDirOut ? (iRise & (~clockGating | running_r)) : extSckRise;
    txFall = clockDirOut ? (iFall & (~clockGating | dataBit)) : extSckFall;
    txSync = pinDirOut[2] ? syncGenTx : mpIn[2];
    if (syncSelect) begin
      rxRise = txRise;
      rxFall = txFall;
      rxSync = pinDirOut[2] ? syncGenRx : mpIn[2];
    end else begin
      rxRise = pinDirOut[0] ? (iRise & (~clockGating | running_r)) : extSc0Rise;
      rxFall = pinDirOut[0] ? (iFall & (~clockGating | dataBit)) : extSc0Fall;
      rxSync = pinDirOut[1] ? syncGenRx : mpIn[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit and receive framers
  ssp_frame_seq #(
    .IS_RX  (1'b0),
    .DATA_W (DATA_W)
  ) u_tx_seq (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .enable     (txEnable),
    .gated      (clockGating),
    .bitLen     (txBitLen),
    .wordLen    (wordLen),
    .slots      (slots),
    .riseEv     (txRise),
    .fallEv     (txFall),
    .syncLvl    (txSync),
    .serIn      (1'b0),
    .parIn      (txWord),
    .serOut     (txdOutW),
    .serOe_n    (txdOeW),
    .parOut     (),
    .wordStrobe (txStrobe),
    .frameStart (txFrameStart),
    .firstBit   (txFirstBit)
  );

  ssp_frame_seq #(
    .IS_RX  (1'b1),
    .DATA_W (DATA_W)
  ) u_rx_seq (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .enable     (rxEnable),
    .gated      (clockGating),
    .bitLen     (rxBitLen),
    .wordLen    (wordLen),
    .slots      (slots),
    .riseEv     (rxRise),
    .fallEv     (rxFall),
    .syncLvl    (rxSync),
    .serIn      (rxdIn),
    .parIn      ('0),
    .serOut     (),
    .serOe_n    (),
    .parOut     (rxWordW),
    .wordStrobe (rxStrobe),
    .frameStart (rxFrameStart),
    .firstBit   (rxFirstBit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Word requests toward the processor side
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txReq  <= 1'b0;
      rxReq  <= 1'b0;
      rxWord <= '0;
    end else begin
      txReq <= txStrobe;
      rxReq <= rxStrobe;
      if (rxStrobe) begin
        rxWord <= rxWordW;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; they only exist while transmit and receive share timing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flagHeld_r <= 2'h0;
      inFlag     <= 2'h0;
    end else begin
      if (txFrameStart || (txFirstBit && clockGating)) begin
        flagHeld_r <= outFlag;
      end
      if (syncSelect && (txFirstBit || rxFirstBit)) begin
        if (!pinDirOut[0]) begin
          inFlag[0] <= mpIn[0];
        end
        if (!pinDirOut[1]) begin
          inFlag[1] <= mpIn[1];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sckOut  <= ssp_pkg::SSP_RST_LVL;
      sckOe_n <= ssp_pkg::SSP_OE_OFF;
      mpOut   <= 3'h0;
      mpOe_n  <= {3{ssp_pkg::SSP_OE_OFF}};
      txdOut  <= ssp_pkg::SSP_RST_LVL;
      txdOe_n <= ssp_pkg::SSP_OE_OFF;
    end else begin
      sckOut  <= clockGating ? (clkLvl_r & dataBit) : clkLvl_r;
      sckOe_n <= ~clockDirOut;
      mpOe_n  <= ~pinDirOut;
      if (syncSelect) begin
        mpOut[1:0] <= flagHeld_r;
      end else begin
        mpOut[0] <= clockGating ? (clkLvl_r & dataBit) : clkLvl_r;
        mpOut[1] <= syncGenRx;
      end
      mpOut[2] <= syncGenTx;
      txdOut   <= txdOutW;
      txdOe_n  <= txdOeW;
    end
  end

endmodule

// >>> verification/ssp_codec_model.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////
// Codec on the shared clock and sync: sends one byte, collects one
module ssp_codec_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Serial pins seen from the codec
  input  wire logic       sck,
  input  wire logic       fs,
  input  wire logic       txd,
  output logic            rxd,
  // Word side
  input  wire logic [7:0] pat,
  output logic [7:0]      capWord
);
  logic       sckPrev;  // Clock one cycle back, for edge finding
  logic [3:0] rIdx;     // Next bit to send, 8 means idle
  logic [3:0] capN;     // Bits collected so far, 8 means idle
  logic [7:0] capSh;    // Collecting shifter
  // One process: drive on the rising clock, sample on the falling clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {sckPrev, rxd} <= 2'h0;
      {rIdx, capN} <= 8'h88;
      {capSh, capWord} <= 16'h0;
    end else begin
      sckPrev <= sck;
      if (sck && !sckPrev) begin
        if (rIdx < 4'h8) begin
          rxd <= pat[3'(4'h7 - rIdx)];
          rIdx <= rIdx + 4'h1;
        end else if (fs) begin
          rxd <= pat[7];
          rIdx <= 4'h1;
          capN <= 4'h0;
        end else begin
          // Idle line shows no stale bit
          rxd <= ~rxd;
        end
      end
      // Device moves data on the rising edge, so the falling edge sees it settled
      if (!sck && sckPrev && capN < 4'h8) begin
        capSh <= {capSh[6:0], txd};
        capN <= capN + 4'h1;
        if (capN == 4'h7) capWord <= {capSh[6:0], txd};
      end
    end
  end
endmodule

// >>> verification/ssp_serial_mode_assertions.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////
// Port-level checks of framing, requests and pin roles
module ssp_serial_mode_assertions #(
  parameter int unsigned DATA_W = 24
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control bits
  input wire logic clockGating,
  input wire logic syncSelect,
  input wire logic frameLenOne,
  input wire logic frameLenZero,
  input wire logic clockDirOut,
  input wire logic txEnable,
  input wire logic prescaleRange,
  input wire logic [2:0] pinDirOut,
  input wire logic [7:0] prescaleModulus,
  input wire logic [1:0] wordLenSel,
  // Outputs watched
  input wire logic txReq,
  input wire logic rxReq,
  input wire logic [DATA_W-1:0] rxWord,
  input wire logic sckOe_n,
  input wire logic [2:0] mpOut,
  input wire logic [2:0] mpOe_n,
  input wire logic txdOe_n
);
  logic [15:0] hiCnt;   // Cycles the shared sync has stood high
  logic [15:0] bitCyc;  // System cycles per bit
  logic [4:0]  wBits;   // Bits per word
  logic        cfgFs;   // Internal shared sync on the third pin
  assign bitCyc = (16'(prescaleModulus) + 16'h1) << (prescaleRange ? 4 : 1);
  assign wBits = (wordLenSel == 2'h3) ? 5'h18 : 5'h08 + 5'(wordLenSel) * 5'h04;
  assign cfgFs = syncSelect & ~clockGating & clockDirOut & pinDirOut[2] & ~frameLenZero;
  // Run length of the sync output; a counter avoids long repetitions
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hiCnt <= 16'h0;
    end else begin
      hiCnt <= mpOut[2] ? hiCnt + 16'h1 : 16'h0;
    end
  end
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wordEnd; $fell(mpOut[2]) && cfgFs && !frameLenOne; endsequence
  sequence s_bitEnd; $fell(mpOut[2]) && cfgFs && frameLenOne; endsequence
  a_sync_word_len: assert property (s_wordEnd |-> hiCnt == wBits * bitCyc)
    else $error("word sync length wrong");
  a_sync_bit_len: assert property (s_bitEnd |-> hiCnt == bitCyc)
    else $error("bit sync length wrong");
  a_tx_req_pulse: assert property (txReq |=> !txReq)
    else $error("transmit request too long");
  a_rx_req_pulse: assert property (rxReq |=> !rxReq)
    else $error("receive request too long");
  a_rx_word_hold: assert property (!rxReq |-> $stable(rxWord))
    else $error("receive word moved without request");
  a_txd_float_off: assert property (!txEnable && !$past(txEnable) && !$past(txEnable, 2) |-> txdOe_n)
    else $error("data driven while transmit off");
  a_txd_drive_word: assert property (txReq && txEnable |-> ##[0:2] !txdOe_n)
    else $error("loaded word not driven");
  a_mp_dir_roles: assert property ($past(arst_n) |-> mpOe_n == ~$past(pinDirOut))
    else $error("pin enable not per direction");
  a_sck_dir_role: assert property ($past(arst_n) |-> sckOe_n == ~$past(clockDirOut))
    else $error("clock enable not per direction");
endmodule

// >>> verification/ssp_serial_mode_top_tb.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////
// Bench: block against a codec on the shared clock and sync
module ssp_serial_mode_top_tb;
  localparam int unsigned DATA_W = 24;
  // Design inputs; the four tied ones select shared internal timing
  // master uses internal clock
  logic sys_clk = 1'b0, arst_n = 1'b0, syncSelect = 1'b1, frameLenZero = 1'b0;
  logic clockDirOut = 1'b1, sckIn = 1'b0, modeSelect = 1'b0, clockGating = 1'b0;
  logic frameLenOne = 1'b0, txEnable = 1'b1, rxEnable = 1'b1, txWordValid = 1'b1;
  logic prescaleRange = 1'b0, rxdIn;
  logic [2:0] pinDirOut = 3'h5, mpIn = 3'h0;
  logic [1:0] outFlag = 2'h0, wordLenSel = 2'h0, inFlag;
  logic [7:0] prescaleModulus = 8'h03, pat = 8'h00, capWord;
  logic [4:0] frameDivider = 5'h01, dv;
  logic [DATA_W-1:0] txWord = '0, rxWord;
  // Design outputs and bench state
  logic txReq, rxReq, sckOut, sckOe_n, txdOut, txdOe_n, ok, ofv, noise = 1'b0;
  logic [2:0] mpOut, mpOe_n;
  int fails = 0, n_tests = 0, rxCnt = 0, txCnt = 0, i, f, n;
  int seed = 32'h04d9580a;

  always #20 sys_clk = ~sys_clk;
  ssp_serial_mode_top #(.DATA_W(DATA_W)) DUT (.*);
  ssp_codec_model codec (.sys_clk(sys_clk), .arst_n(arst_n), .sck(sckOut), .fs(mpOut[2]),
    .txd(txdOut), .rxd(rxdIn), .pat(pat), .capWord(capWord));

  // Request counters, and noise on inputs that must be ignored
  always @(posedge sys_clk) begin
    if (rxReq === 1'b1) rxCnt <= rxCnt + 1;
    if (txReq === 1'b1) txCnt <= txCnt + 1;
    if (noise) mpIn <= 3'($random(seed));
  end

  task chk(input logic [DATA_W-1:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Mode bits only change while reset is held
  task setup(input logic md, gk, f1, input logic [4:0] d, input logic [1:0] wl,
             input logic [2:0] pd, input logic [7:0] pm);
    arst_n <= 1'b0;
    {modeSelect, clockGating, frameLenOne} <= {md, gk, f1};
    {frameDivider, wordLenSel, pinDirOut, prescaleModulus} <= {d, wl, pd, pm};
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
  endtask

  task automatic wait_hi(ref logic s, output logic got);
    int k;
    got = 1'b0;
    for (k = 0; k < 4000 && !got; k++) begin
      @(posedge sys_clk);
      got = (s === 1'b1);
    end
  endtask

  // Next rising edge of the shared sync, bounded
  task wait_fs;
    int k;
    for (k = 0; k < 4000 && mpOut[2] !== 1'b0; k++) @(posedge sys_clk);
    for (k = 0; k < 4000 && mpOut[2] !== 1'b1; k++) @(posedge sys_clk);
  endtask

  initial begin
    // Normal continuous frames with a gap: data, flags, noise on output pins
    setup(1'b0, 1'b0, 1'b0, 5'h01, 2'h0, 3'h5, 8'h03);
    for (f = 0; f < 8; f++) begin
      pat <= 8'($random(seed));
      txWord <= DATA_W'(8'($random(seed)));
      mpIn <= 3'($random(seed));
      ofv = 1'($random(seed));
      outFlag <= {1'b0, ofv};
      wait_hi(txReq, ok);
      outFlag <= {1'b0, ~ofv};
      wait_hi(rxReq, ok);
      chk(ok, 1'b1);
      if (f > 0) begin
        chk(rxWord, DATA_W'(pat));
        chk(mpOut[0], ofv);
        chk(inFlag[1], mpIn[1]);
        repeat (8) @(posedge sys_clk);
        chk(capWord, txWord[7:0]);
      end
    end
    // Words per frame over modes, word lengths and sync kinds
    for (i = 0; i < 4; i++) begin
      dv = (i == 3) ? 5'h1f : 5'(i + 1);
      prescaleRange <= (i == 1);
      setup(i != 0, 1'b0, i[0], dv, 2'(i), 3'h4, 8'h00);
      wait_fs;
      wait_fs;
      n = rxCnt;
      wait_fs;
      chk(DATA_W'(rxCnt - n), (i == 0) ? 24'h1 : DATA_W'(dv) + 24'h1);
    end
    // Gated clock: noise on the sync input must not stop frames
    setup(1'b0, 1'b1, 1'b0, 5'h01, 2'h0, 3'h0, 8'h01);
    noise = 1'b1;
    wait_hi(rxReq, ok);
    wait_hi(rxReq, ok);
    chk(ok, 1'b1);
    noise = 1'b0;
    // On-demand: no frame until a word waits
    txWordValid <= 1'b0;
    rxEnable <= 1'b0;
    setup(1'b1, 1'b1, 1'b0, 5'h00, 2'h0, 3'h4, 8'h01);
    n = txCnt;
    repeat (300) @(posedge sys_clk);
    chk(DATA_W'(txCnt - n), 24'h0);
    txWordValid <= 1'b1;
    wait_hi(txReq, ok);
    chk(ok, 1'b1);
    // Transmit switched off: data pin floats
    txEnable <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk(txdOe_n, 1'b1);
    close_out;
  end

  // Watchdog well past the expected run length
  initial begin
    #2000000;
    fails++;
    close_out;
  end
endmodule

bind ssp_serial_mode_top ssp_serial_mode_assertions #(.DATA_W(DATA_W)) u_chk (.*);
